//--- design/port_pin_function_select.sv
`timescale 1ns/10ps
`include "port_pin_map.svh"

module port_pin_function_select #(
	parameter logic [3:0] CLK_SEL_RC_INTERNAL = 4'h1
) (
	// Clock and reset
	input  wire logic                        ref_clk_i,
	input  wire logic                        srst_i,
	// Fuses and control
	input  wire logic                        reset_pin_disable_fuse_i,
	input  wire logic [`CLK_SEL_W-1:0]       clk_sel_fuse_i,
	input  wire logic                        async_timer_clock_select_i,
	input  wire logic                        other_reset_i,
	// Port register values from the core
	input  wire logic [`WIDE_PORT_W-1:0]     pb_out_i,
	input  wire logic [`WIDE_PORT_W-1:0]     pb_dir_i,
	input  wire logic [`WIDE_PORT_W-1:0]     pb_pull_en_i,
	input  wire logic [`NARROW_PORT_W-1:0]   pc_out_i,
	input  wire logic [`NARROW_PORT_W-1:0]   pc_dir_i,
	input  wire logic [`NARROW_PORT_W-1:0]   pc_pull_en_i,
	input  wire logic [`WIDE_PORT_W-1:0]     pd_out_i,
	input  wire logic [`WIDE_PORT_W-1:0]     pd_dir_i,
	input  wire logic [`WIDE_PORT_W-1:0]     pd_pull_en_i,
	// Pin levels from the pads
	input  wire logic [`WIDE_PORT_W-1:0]     pb_pin_i,
	input  wire logic [`NARROW_PORT_W-1:0]   pc_pin_i,
	input  wire logic [`WIDE_PORT_W-1:0]     pd_pin_i,
	// Pad drive
	output logic      [`WIDE_PORT_W-1:0]     pb_pin_o,
	output logic      [`WIDE_PORT_W-1:0]     pb_pin_oe_o,
	output logic      [`WIDE_PORT_W-1:0]     pb_pin_pull_o,
	output logic      [`NARROW_PORT_W-1:0]   pc_pin_o,
	output logic      [`NARROW_PORT_W-1:0]   pc_pin_oe_o,
	output logic      [`NARROW_PORT_W-1:0]   pc_pin_pull_o,
	output logic      [`WIDE_PORT_W-1:0]     pd_pin_o,
	output logic      [`WIDE_PORT_W-1:0]     pd_pin_oe_o,
	output logic      [`WIDE_PORT_W-1:0]     pd_pin_pull_o,
	// Synchronised pin levels back to the core
	output logic      [`WIDE_PORT_W-1:0]     pb_in_o,
	output logic      [`NARROW_PORT_W-1:0]   pc_in_o,
	output logic      [`WIDE_PORT_W-1:0]     pd_in_o,
	// Alternate functions
	output logic                             ext_reset_o,
	output port_pin_pkg::osc_mode_t          osc_mode_o,
	output logic                             crystal_amp_input_o,
	output logic                             timer_osc_input_o,
	output logic                             timer_osc_output_o
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [`WIDE_PORT_W-1:0]   pb_meta;
		logic [`WIDE_PORT_W-1:0]   pb_sync;
		logic [`NARROW_PORT_W-1:0] pc_meta;
		logic [`NARROW_PORT_W-1:0] pc_sync;
		logic [`WIDE_PORT_W-1:0]   pd_meta;
		logic [`WIDE_PORT_W-1:0]   pd_sync;
		logic [`RESET_CNT_W-1:0]   low_cnt;
		logic                      ext_reset;
		port_pin_pkg::osc_mode_t   osc_mode;
		logic                      xtal_in;
		logic                      tosc_in;
		logic                      tosc_out;
	} sel_state_t;

	// Counter saturates at the threshold so a long hold cannot wrap
	localparam logic [`RESET_CNT_W-1:0] RESET_CYCLES = `RESET_CNT_W'(`RESET_PULSE_CYCLES);

	sel_state_t state;
	sel_state_t next_state;

	// Combinational decode shared by the pad cells and the state update
	logic                      rst_pin_mode;
	logic                      any_reset;
	port_pin_pkg::osc_mode_t   sel_mode;
	logic [`WIDE_PORT_W-1:0]   pb_takeover;
	logic [`NARROW_PORT_W-1:0] pc_takeover;

	// ------------------------------------------------------------
	// Reset sources
	// ------------------------------------------------------------
	always_comb
	begin
		rst_pin_mode = ~reset_pin_disable_fuse_i;
		// A low shared pin in reset mode drops the pads at once
		any_reset = srst_i | other_reset_i | state.ext_reset
			| (rst_pin_mode & ~pc_pin_i[`SHARED_RESET_BIT]);
	end

	// ------------------------------------------------------------
	// Function selection
	// ------------------------------------------------------------
	// Decoded from the fuses, not the mode register, so the pad release
	// and the mode output move on the same edge
	always_comb
	begin
		sel_mode = port_pin_pkg::OSC_MODE_CRYSTAL;
		if (clk_sel_fuse_i == CLK_SEL_RC_INTERNAL)
		begin
			if (async_timer_clock_select_i)
				sel_mode = port_pin_pkg::OSC_MODE_TIMER;
			else
				sel_mode = port_pin_pkg::OSC_MODE_PORT;
		end
		pc_takeover = '0;
		pc_takeover[`SHARED_RESET_BIT] = rst_pin_mode;
		pb_takeover = '0;
		if (sel_mode != port_pin_pkg::OSC_MODE_PORT)
		begin
			pb_takeover[`OSC_INPUT_BIT]  = 1'b1;
			pb_takeover[`OSC_OUTPUT_BIT] = 1'b1;
		end
	end

	always_comb
	begin
		next_state = state;
		next_state.pb_meta = pb_pin_i;
		next_state.pb_sync = state.pb_meta;
		next_state.pc_meta = pc_pin_i;
		next_state.pc_sync = state.pc_meta;
		next_state.pd_meta = pd_pin_i;
		next_state.pd_sync = state.pd_meta;
		// Filtered reset: low must persist the minimum pulse time
		if (rst_pin_mode && !state.pc_sync[`SHARED_RESET_BIT])
		begin
			if (state.low_cnt < RESET_CYCLES)
				next_state.low_cnt = state.low_cnt + `RESET_CNT_W'(1);
		end
		else
			next_state.low_cnt = '0;
		next_state.ext_reset = (next_state.low_cnt >= RESET_CYCLES);
		next_state.osc_mode = sel_mode;
		// Routed levels trail the pins by three edges through the synchroniser
		next_state.xtal_in = (state.osc_mode == port_pin_pkg::OSC_MODE_CRYSTAL)
			& state.pb_sync[`OSC_INPUT_BIT];
		next_state.tosc_in = (state.osc_mode == port_pin_pkg::OSC_MODE_TIMER)
			& state.pb_sync[`OSC_INPUT_BIT];
		next_state.tosc_out = (state.osc_mode == port_pin_pkg::OSC_MODE_TIMER)
			& state.pb_sync[`OSC_OUTPUT_BIT];
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			state          <= '0;
			// Synchronisers start at the idle high level of the pull-ups
			state.pb_meta  <= '1;
			state.pb_sync  <= '1;
			state.pc_meta  <= '1;
			state.pc_sync  <= '1;
			state.pd_meta  <= '1;
			state.pd_sync  <= '1;
		end
		else
			state <= next_state;
	end

	// ------------------------------------------------------------
	// Port cells
	// ------------------------------------------------------------
	pin_port_cell #(.W(`WIDE_PORT_W)) port_b (
		.ref_clk_i   (ref_clk_i),
		.srst_i      (srst_i),
		.any_reset_i (any_reset),
		.port_out_i  (pb_out_i),
		.port_dir_i  (pb_dir_i),
		.pull_en_i   (pb_pull_en_i),
		.takeover_i  (pb_takeover),
		.pin_out_o   (pb_pin_o),
		.pin_oe_o    (pb_pin_oe_o),
		.pin_pull_o  (pb_pin_pull_o)
	);

	pin_port_cell #(.W(`NARROW_PORT_W)) port_c (
		.ref_clk_i   (ref_clk_i),
		.srst_i      (srst_i),
		.any_reset_i (any_reset),
		.port_out_i  (pc_out_i),
		.port_dir_i  (pc_dir_i),
		.pull_en_i   (pc_pull_en_i),
		.takeover_i  (pc_takeover),
		.pin_out_o   (pc_pin_o),
		.pin_oe_o    (pc_pin_oe_o),
		.pin_pull_o  (pc_pin_pull_o)
	);

	// Port D has no alternate function in this block
	pin_port_cell #(.W(`WIDE_PORT_W)) port_d (
		.ref_clk_i   (ref_clk_i),
		.srst_i      (srst_i),
		.any_reset_i (any_reset),
		.port_out_i  (pd_out_i),
		.port_dir_i  (pd_dir_i),
		.pull_en_i   (pd_pull_en_i),
		.takeover_i  ('0),
		.pin_out_o   (pd_pin_o),
		.pin_oe_o    (pd_pin_oe_o),
		.pin_pull_o  (pd_pin_pull_o)
	);

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	always_comb
	begin
		pb_in_o             = state.pb_sync;
		// The shared pin reads zero while it serves as the reset input
		pc_in_o             = state.pc_sync & ~pc_takeover;
		pd_in_o             = state.pd_sync;
		ext_reset_o         = state.ext_reset;
		osc_mode_o          = state.osc_mode;
		crystal_amp_input_o = state.xtal_in;
		timer_osc_input_o   = state.tosc_in;
		timer_osc_output_o  = state.tosc_out;
	end

endmodule : port_pin_function_select

//--- design/port_pin_map.svh
// Overview of operation
// - Any reset tri-states every port pin immediately
// - Eight-bit ports have per-bit pull-up enables
// - Seven-bit port, top bit is shared reset
// - Fuse programmed: shared reset pin is plain I/O
// - Fuse unprogrammed: shared pin is active-low reset
// - Long enough low pulse resets, short may not
// - Clock fuses route crystal amplifier to oscillator pins
// - RC clock plus timer select: pins feed timer oscillator
`ifndef PORT_PIN_MAP_SVH
`define PORT_PIN_MAP_SVH

`define WIDE_PORT_W        8
`define NARROW_PORT_W      7
`define SHARED_RESET_BIT   6
`define OSC_INPUT_BIT      6
`define OSC_OUTPUT_BIT     7
`define CLK_SEL_W          4
// Minimum external reset low time, in ns
`define RESET_PULSE_NS     1500
`define REF_CLK_PERIOD_NS  50
`define RESET_PULSE_CYCLES ((`RESET_PULSE_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)
`define RESET_CNT_W        8

`endif

//--- design/port_pin_pkg.sv
package port_pin_pkg;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] pull;
	} wide_pins_t;

	typedef struct packed {
		logic [6:0] out;
		logic [6:0] oe;
		logic [6:0] pull;
	} narrow_pins_t;

	typedef enum logic [1:0] {
		OSC_MODE_PORT    = 2'b00,
		OSC_MODE_CRYSTAL = 2'b01,
		OSC_MODE_TIMER   = 2'b10
	} osc_mode_t;

endpackage : port_pin_pkg

//--- design/pin_port_cell.sv
`timescale 1ns/10ps
`include "port_pin_map.svh"

// One port of W bits: registered drive, per-bit pull-up, release on takeover
module pin_port_cell #(
	parameter int W = 8
) (
	input  wire logic         ref_clk_i,
	input  wire logic         srst_i,
	input  wire logic         any_reset_i,
	input  wire logic [W-1:0] port_out_i,
	input  wire logic [W-1:0] port_dir_i,
	input  wire logic [W-1:0] pull_en_i,
	input  wire logic [W-1:0] takeover_i,
	output logic      [W-1:0] pin_out_o,
	output logic      [W-1:0] pin_oe_o,
	output logic      [W-1:0] pin_pull_o
);

	typedef struct packed {
		logic [W-1:0] out;
		logic [W-1:0] oe;
		logic [W-1:0] pull;
	} cell_state_t;

	cell_state_t state;
	cell_state_t next_state;

	always_comb
	begin
		next_state.out  = port_out_i & ~takeover_i;
		next_state.oe   = port_dir_i & ~takeover_i;
		next_state.pull = pull_en_i & ~port_dir_i & ~takeover_i;
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
			state <= '0;
		else
			state <= next_state;
	end

	// Reset gating is kept combinational so the pads drop with no clock edge
	always_comb
	begin
		pin_out_o  = state.out & {W{~any_reset_i}};
		pin_oe_o   = state.oe & {W{~any_reset_i}};
		pin_pull_o = state.pull & {W{~any_reset_i}};
	end

endmodule : pin_port_cell

//--- verif/board_pins.sv
`timescale 1ns/10ps

// ----------------------------------------
// Board wiring at the port pins
// ----------------------------------------
module board_pins #(
	parameter int W = 23
) (
	// Clock
	input  wire logic         ref_clk_i,
	// Pad drive and board drive
	input  wire logic [W-1:0] pad_out_i,
	input  wire logic [W-1:0] pad_oe_i,
	input  wire logic [W-1:0] pad_pull_i,
	input  wire logic [W-1:0] ext_en_i,
	input  wire logic [W-1:0] ext_val_i,
	// Resolved level
	output logic      [W-1:0] level_o
);
	logic [W-1:0] flt = '0;

	// Undriven lines wander so a stale level is never trusted
	always_ff @(posedge ref_clk_i)
		flt <= ~flt;

	always_comb
		level_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_en_i & ext_val_i)
			| (~pad_oe_i & ~ext_en_i & (pad_pull_i | flt));
endmodule : board_pins

//--- verif/port_pin_function_select_props.sv
`timescale 1ns/10ps

module pin_select_props #(
	parameter logic [3:0] CLK_SEL_RC_INTERNAL = 4'h1
) (
	// Inputs
	input wire logic                    ref_clk_i,
	input wire logic                    srst_i,
	input wire logic                    reset_pin_disable_fuse_i,
	input wire logic [3:0]              clk_sel_fuse_i,
	input wire logic                    async_timer_clock_select_i,
	input wire logic                    other_reset_i,
	input wire logic [7:0]              pd_dir_i,
	input wire logic [7:0]              pd_pull_en_i,
	input wire logic [6:0]              pc_dir_i,
	input wire logic [6:0]              pc_pin_i,
	input wire logic [7:0]              pb_pin_i,
	// Outputs
	input wire logic [7:0]              pb_pin_oe_o,
	input wire logic [7:0]              pb_pin_pull_o,
	input wire logic [6:0]              pc_pin_oe_o,
	input wire logic [6:0]              pc_pin_pull_o,
	input wire logic [7:0]              pd_pin_oe_o,
	input wire logic [7:0]              pd_pin_pull_o,
	input wire logic                    ext_reset_o,
	input wire port_pin_pkg::osc_mode_t osc_mode_o,
	input wire logic                    timer_osc_input_o
);
	logic [7:0] low_cnt;
	wire        fz = reset_pin_disable_fuse_i;
	wire        quiet = !other_reset_i && !ext_reset_o && (fz || pc_pin_i[6]);

	// Cycles the reset pin has been held low
	always_ff @(posedge ref_clk_i)
		if (srst_i || fz || pc_pin_i[6])
			low_cnt <= 8'h00;
		else if (low_cnt != 8'hff)
			low_cnt <= low_cnt + 8'h01;

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);

	AST_ANY_RESET_TRI: assert property (disable iff (1'b0)
		(srst_i || other_reset_i || ext_reset_o) |-> !(|{pb_pin_oe_o, pc_pin_oe_o, pd_pin_oe_o}))
		else $error("pads driven in reset");
	AST_PORT_DRIVE: assert property (quiet && !$past(srst_i) |-> pd_pin_oe_o == $past(pd_dir_i)
		&& pd_pin_pull_o == $past(pd_pull_en_i & ~pd_dir_i) && pc_pin_oe_o[5:0] == $past(pc_dir_i[5:0]))
		else $error("port drive wrong");
	AST_SHARED_IO: assert property (quiet && fz && $past(fz) && !$past(srst_i) |->
		pc_pin_oe_o[6] == $past(pc_dir_i[6])) else $error("shared pin not io");
	AST_SHARED_TAKEN: assert property (!fz && !$past(fz) |->
		!pc_pin_oe_o[6] && !pc_pin_pull_o[6]) else $error("reset pin driven");
	AST_EXT_LONG: assert property (low_cnt >= 8'h24 |-> ext_reset_o)
		else $error("long low gave no reset");
	AST_MODE: assert property (!$past(srst_i) |-> osc_mode_o ==
		(($past(clk_sel_fuse_i) != CLK_SEL_RC_INTERNAL) ? port_pin_pkg::OSC_MODE_CRYSTAL :
		$past(async_timer_clock_select_i) ? port_pin_pkg::OSC_MODE_TIMER : port_pin_pkg::OSC_MODE_PORT))
		else $error("osc mode wrong");
	AST_OSC_TAKE: assert property (osc_mode_o != port_pin_pkg::OSC_MODE_PORT |->
		pb_pin_oe_o[7:6] == 2'b00 && pb_pin_pull_o[7:6] == 2'b00) else $error("osc pin driven");
	AST_TIMER_ROUTE: assert property ((osc_mode_o == port_pin_pkg::OSC_MODE_TIMER)[*4] |->
		timer_osc_input_o == $past(pb_pin_i[6], 3)) else $error("timer input not routed");

	COV_EXT: cover property ($rose(ext_reset_o));
	COV_TIMER: cover property (osc_mode_o == port_pin_pkg::OSC_MODE_TIMER);
	COV_XTAL: cover property (osc_mode_o == port_pin_pkg::OSC_MODE_CRYSTAL);
endmodule : pin_select_props

bind port_pin_function_select pin_select_props #(
	.CLK_SEL_RC_INTERNAL(CLK_SEL_RC_INTERNAL)
) props (.*);

//--- verif/tb_top.sv
`timescale 1ns/10ps

module tb_top;
	logic                       ref_clk_i = 1'b0;
	logic                       srst_i = 1'b1;
	logic                       fuse = 1'b1;
	logic                       tsel = 1'b0;
	logic                       oth = 1'b0;
	logic                       ext_rst;
	logic [3:0]                 csel = 4'h1;
	logic [22:0]                x_en = 23'h4000;
	logic [22:0]                x_val = 23'h4000;
	logic [22:0]                lvl;
	logic [22:0]                pin_in;
	logic [2:0]                 route;
	logic [22:0]                lvl_q[$];
	port_pin_pkg::wide_pins_t   b_req = '0, d_req = '0, b_pad, d_pad;
	port_pin_pkg::narrow_pins_t c_req = '0, c_pad;
	port_pin_pkg::osc_mode_t    mode;
	int                         bad_count = 0;
	int                         n_compared = 0;
	int                         k;

	always #25 ref_clk_i = ~ref_clk_i;

	// Pin levels as the pads saw them at the last three edges, oldest first
	always @(posedge ref_clk_i)
	begin
		lvl_q.push_back(lvl);
		if (lvl_q.size() > 3)
			void'(lvl_q.pop_front());
	end

	port_pin_function_select dut (
		.ref_clk_i(ref_clk_i), .srst_i(srst_i), .reset_pin_disable_fuse_i(fuse),
		.clk_sel_fuse_i(csel), .async_timer_clock_select_i(tsel), .other_reset_i(oth),
		.pb_out_i(b_req.out), .pb_dir_i(b_req.oe), .pb_pull_en_i(b_req.pull),
		.pc_out_i(c_req.out), .pc_dir_i(c_req.oe), .pc_pull_en_i(c_req.pull),
		.pd_out_i(d_req.out), .pd_dir_i(d_req.oe), .pd_pull_en_i(d_req.pull),
		.pb_pin_i(lvl[22:15]), .pc_pin_i(lvl[14:8]), .pd_pin_i(lvl[7:0]),
		.pb_pin_o(b_pad.out), .pb_pin_oe_o(b_pad.oe), .pb_pin_pull_o(b_pad.pull),
		.pc_pin_o(c_pad.out), .pc_pin_oe_o(c_pad.oe), .pc_pin_pull_o(c_pad.pull),
		.pd_pin_o(d_pad.out), .pd_pin_oe_o(d_pad.oe), .pd_pin_pull_o(d_pad.pull),
		.pb_in_o(pin_in[22:15]), .pc_in_o(pin_in[14:8]), .pd_in_o(pin_in[7:0]),
		.ext_reset_o(ext_rst), .osc_mode_o(mode), .crystal_amp_input_o(route[2]),
		.timer_osc_input_o(route[1]), .timer_osc_output_o(route[0])
	);

	board_pins #(.W(23)) board (
		.ref_clk_i(ref_clk_i), .pad_out_i({b_pad.out, c_pad.out, d_pad.out}),
		.pad_oe_i({b_pad.oe, c_pad.oe, d_pad.oe}), .pad_pull_i({b_pad.pull, c_pad.pull, d_pad.pull}),
		.ext_en_i(x_en), .ext_val_i(x_val), .level_o(lvl)
	);

	task automatic chk(input string nm, input logic [22:0] e, input logic [22:0] g);
		n_compared++;
		if (g !== e)
		begin
			bad_count++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	task automatic finish_test();
		$display("compared %0d bad %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : finish_test

	// ----------------------------------------
	// Random port traffic against the model
	// ----------------------------------------
	task automatic run(input int n);
		logic [22:0] tk, po, pp, pv, oe;
		logic [1:0]  em;
		logic [2:0]  rt;
		for (int i = 0; i < n; i++)
		begin
			@(posedge ref_clk_i);
			#1;
			tk = {((csel != 4'h1 || tsel) ? 8'hc0 : 8'h00), (fuse ? 7'h00 : 7'h40), 8'h00};
			oe = {b_pad.oe, c_pad.oe, d_pad.oe};
			if (i > 1)
			begin
				chk("oe", po & ~tk, oe);
				chk("pull", pp & ~po & ~tk, {b_pad.pull, c_pad.pull, d_pad.pull});
				chk("out", pv & po & ~tk, {b_pad.out, c_pad.out, d_pad.out} & oe);
				chk("mode", (csel != 4'h1) ? 23'h1 : {21'h0, tsel, 1'b0}, 23'(mode));
				em = (csel != 4'h1) ? 2'h1 : {tsel, 1'b0};
				rt = {em == 2'h1 && lvl_q[0][21], em == 2'h2 && lvl_q[0][21],
					em == 2'h2 && lvl_q[0][22]};
				chk("in", lvl_q[1] & ~{8'h00, tk[14:8], 8'h00}, pin_in);
				chk("route", {20'h0, rt}, {20'h0, route});
			end
			{b_req, c_req, d_req} = 69'({$urandom, $urandom, $urandom});
			po = {b_req.oe, c_req.oe, d_req.oe};
			pp = {b_req.pull, c_req.pull, d_req.pull};
			pv = {b_req.out, c_req.out, d_req.out};
			x_en = 23'($urandom) | 23'h4000;
			x_val = 23'($urandom) | 23'h4000;
		end
	endtask : run

	initial
	begin
		void'($urandom(32'h21d70f03));
		repeat (8) @(posedge ref_clk_i);
		#1;
		srst_i = 1'b0;
		for (int f = 0; f < 2; f++)
			for (int m = 0; m < 3; m++)
			begin
				fuse = f[0];
				csel = (m == 2) ? 4'h2 : 4'h1;
				tsel = (m == 1);
				run(40);
			end
		// Other reset source, seen with no clock edge
		@(posedge ref_clk_i);
		#1;
		oth = 1'b1;
		// Shared pin turns into the reset input while the pads are held off
		fuse = 1'b0;
		#1;
		chk("oth_tri", 23'h0, {b_pad.oe, c_pad.oe, d_pad.oe});
		@(posedge ref_clk_i);
		#1;
		oth = 1'b0;
		run(4);
		@(posedge ref_clk_i);
		#1;
		x_val[14] = 1'b0;
		#1;
		chk("pin_tri", 23'h0, {b_pad.oe, c_pad.oe, d_pad.oe});
		for (k = 0; k < 60 && ext_rst !== 1'b1; k++)
		begin
			@(posedge ref_clk_i);
			#1;
		end
		chk("ext_rst", 23'h1, {22'h0, ext_rst === 1'b1 && k >= 30});
		if (ext_rst !== 1'b1)
			finish_test();
		#1;
		x_val[14] = 1'b1;
		repeat (8) @(posedge ref_clk_i);
		#1;
		chk("ext_rst_off", 23'h0, {22'h0, ext_rst});
		srst_i = 1'b1;
		repeat (2) @(posedge ref_clk_i);
		#1;
		chk("srst_tri", 23'h0, {b_pad.oe, c_pad.oe, d_pad.oe});
		chk("srst_mode", 23'h0, 23'(mode));
		srst_i = 1'b0;
		run(10);
		finish_test();
	end
endmodule : tb_top
